// ===== bench/nbb_flash_model.sv
// Purpose: Behavioural flash array on the far side of the host sequencer.
// Assumes: Pins change only on i_clk edges; R/B high means ready.
// Notes:   Erase keeps stored bytes, so tests never read an erased page.
`timescale 1ns/1ps
`default_nettype none
module nbb_flash_model (
	// Pins from the host
	input  wire logic       i_clk,
	input  wire logic       i_ce_n,
	input  wire logic       i_cle,
	input  wire logic       i_ale,
	input  wire logic       i_we_n,
	input  wire logic       i_re_n,
	input  wire logic [7:0] i_io,
	// Fault control and answers
	input  wire logic       i_fail,
	output logic      [7:0] o_io,
	output logic            o_rb
);
	logic [7:0]  mem [int];
	logic [7:0]  dout = 8'h00;
	logic [11:0] col  = 12'h000;
	logic [14:0] row  = 15'h0000;
	logic        we_q = 1'b1, re_q = 1'b1, stat = 1'b0, fail = 1'b0;
	int          ai   = 0, busy = 0, n_mark = 0;
	assign o_rb = busy == 0;
	// A released bus shows the inverse of the last byte, so a stale copy never passes.
	assign o_io = (!i_ce_n && !i_re_n) ? dout : ~dout;
	always @(posedge i_clk) begin
		if (busy > 0) busy <= busy - 1;
		if (!i_ce_n && i_we_n && !we_q) begin
			if (i_cle) begin
				ai = (i_io == 8'h60) ? 2 : 0;
				stat = i_io == 8'h70;
				if (i_io == 8'h30 || i_io == 8'h10 || i_io == 8'hd0) begin
					busy <= 20;
					fail = i_fail && i_io != 8'h30;
				end
			end else if (i_ale) begin
				case (ai)
					0: col[7:0] = i_io;
					1: col[11:8] = i_io[3:0];
					2: row[7:0] = i_io;
					default: row[14:8] = i_io[6:0];
				endcase
				ai++;
			end else begin
				mem[{row, col}] = i_io;
				col++;
			end
		end
		if (!i_ce_n && !i_re_n && re_q) begin
			if (stat) dout <= {1'b0, busy == 0, 5'h00, fail};
			else begin
				n_mark += int'(col == 12'h800);
				// Blocks 5 and 300 carry the bad mark; block zero never does.
				if (col == 12'h800 && row[5:0] == 0 && (row[14:6] == 5 || row[14:6] == 300)) dout <= 8'h00;
				else dout <= mem.exists({row, col}) ? mem[{row, col}] : 8'hff;
				col++;
			end
		end
		we_q <= i_we_n;
		re_q <= i_re_n;
	end
endmodule
`default_nettype wire

// ===== bench/tb_nbb_host.sv
// Purpose: Self-checking bench for the NAND host sequencer.
// Assumes: Flash model turns busy for 20 cycles; spares come from block 511 down.
// Notes:   The scan of 512 blocks takes most of the run.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module tb_nbb_host;
	logic              i_clk = 1'b0, i_rst = 1'b1, i_req_valid = 1'b0, i_wr_valid = 1'b0, fail = 1'b0;
	logic [7:0]        i_wr_data = 8'h00, lf = 8'h4d, o_rd_data, o_io_out, flash_io, io_in;
	logic              o_done, o_scan_done, o_wr_taken, o_rd_valid, o_rd_unit_end, o_io_oe, rb, busy, wp_n;
	logic              o_ce_n, o_cle, o_ale, o_we_n, o_re_n;
	nbb_pkg::nbb_req_s i_req = '0;
	nbb_pkg::nbb_res_s o_res, res;
	logic [7:0]        wr_q[$], rd_q[$], exp_q[$];
	int                n_errors = 0, compares = 0, n_ue = 0;
	nbb_host nbb_host_inst (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req(i_req), .o_busy(busy),
		.o_done(o_done), .o_res(o_res), .o_scan_done(o_scan_done), .i_wr_valid(i_wr_valid), .i_wr_data(i_wr_data),
		.o_wr_taken(o_wr_taken), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_rd_unit_end(o_rd_unit_end),
		.o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale), .o_we_n(o_we_n), .o_re_n(o_re_n), .o_wp_n(wp_n),
		.o_io_out(o_io_out), .o_io_oe(o_io_oe), .i_io_in(io_in), .i_rb(rb));
	nbb_flash_model nbb_flash_model_inst (.i_clk(i_clk), .i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale),
		.i_we_n(o_we_n), .i_re_n(o_re_n), .i_io(io_in), .i_fail(fail), .o_io(flash_io), .o_rb(rb));
	assign io_in = o_io_oe ? o_io_out : flash_io;
	always #5 i_clk = ~i_clk;
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	// Each byte stays offered until the host reports it taken.
	always @(posedge i_clk) begin
		if (o_wr_taken) wr_q.delete(0);
		i_wr_valid <= wr_q.size() != 0;
		i_wr_data <= (wr_q.size() != 0) ? wr_q[0] : 8'h00;
		if (o_rd_valid) rd_q.push_back(o_rd_data);
		n_ue += int'(o_rd_unit_end);
	end
	task automatic req(input nbb_pkg::nbb_op_e op, input int b, input int p);
		@(posedge i_clk);
		i_req_valid <= 1'b1;
		i_req <= '{op, 9'(b), 6'(p)};
		@(posedge i_clk);
		i_req_valid <= 1'b0;
		@(negedge i_clk);
		`CHK("busy", 1'b1, busy)
		do @(negedge i_clk); while (o_done !== 1'b1);
		res = o_res;
	endtask
	task automatic test_done;
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (95000) @(posedge i_clk);
		n_errors++;
		test_done();
	end
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		req(nbb_pkg::NBB_OP_ERASE, 9, 0);
		`CHK("early erase refused", 1'b1, res.refused)
		$display("test early done");
		req(nbb_pkg::NBB_OP_SCAN, 0, 0);
		`CHK("scan done", 1'b1, o_scan_done)
		`CHK("marker reads", 512, nbb_flash_model_inst.n_mark)
		`CHK("write protect off", 1'b1, wp_n)
		req(nbb_pkg::NBB_OP_ERASE, 5, 0);
		`CHK("bad erase refused", 1'b1, res.refused)
		req(nbb_pkg::NBB_OP_PROG, 300, 0);
		`CHK("bad program refused", 1'b1, res.refused)
		$display("test scan done");
		for (int k = 0; k < 2112; k++) begin
			lf = lfsr(lf);
			wr_q.push_back(lf);
			exp_q.push_back(lf);
		end
		req(nbb_pkg::NBB_OP_PROG, 7, 3);
		`CHK("program ok", 1'b1, res.ok)
		`CHK("program row", 15'h01c3, nbb_flash_model_inst.row)
		`CHK("program column end", 12'h840, nbb_flash_model_inst.col)
		rd_q.delete();
		n_ue = 0;
		req(nbb_pkg::NBB_OP_READ, 7, 3);
		`CHK("read length", 2112, rd_q.size())
		foreach (exp_q[k]) `CHK("read byte", exp_q[k], rd_q[k])
		`CHK("ecc units", 5, n_ue)
		for (int p = 2; p < 4; p++) begin
			req(nbb_pkg::NBB_OP_PROG, 7, p);
			`CHK("page order refused", 1'b1, res.refused)
		end
		// A higher page in the same block must still be accepted.
		for (int k = 0; k < 2112; k++) begin
			lf = lfsr(lf);
			wr_q.push_back(lf);
		end
		req(nbb_pkg::NBB_OP_PROG, 7, 4);
		`CHK("next page accepted", 1'b1, res.ok)
		$display("test page done");
		fail <= 1'b1;
		req(nbb_pkg::NBB_OP_ERASE, 9, 0);
		`CHK("erase failed", 1'b1, res.failed)
		`CHK("spare block", 9'h1ff, res.block)
		fail <= 1'b0;
		req(nbb_pkg::NBB_OP_ERASE, 9, 0);
		`CHK("remapped erase", 9'h1ff, nbb_flash_model_inst.row[14:6])
		$display("test remap done");
		test_done();
	end
endmodule
`default_nettype wire

// ===== logic/nbb_addr.sv
// Purpose: Picks the byte for one address cycle from column and row.
// Assumes: Four address cycles, column first.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module nbb_addr (
	// Address parts
	input  wire logic [11:0] i_col,
	input  wire logic [14:0] i_row,
	input  wire logic [1:0]  i_idx,
	// Selected byte
	output logic      [7:0]  o_byte
);
	always_comb begin
		case (i_idx)
			2'h0:    o_byte = i_col[7:0];
			2'h1:    o_byte = {4'h0, i_col[11:8]};
			2'h2:    o_byte = i_row[7:0];
			default: o_byte = {1'b0, i_row[14:8]};
		endcase
	end
endmodule
`default_nettype wire

// ===== logic/nbb_cycle.sv
// Purpose: Runs one strobed bus cycle or a timed wait on the flash pins.
// Assumes: Pins sampled synchronously to i_clk.
// Notes:   Every pin output is a flip-flop.
`timescale 1ns/1ps
`default_nettype none
module nbb_cycle (
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	// Request
	input  wire logic              i_start,
	input  wire nbb_pkg::nbb_kind_e i_kind,
	input  wire logic [7:0]        i_byte,
	input  wire logic [7:0]        i_wait,
	output logic                   o_done,
	output logic      [7:0]        o_byte,
	// Pins
	output logic                   o_cle,
	output logic                   o_ale,
	output logic                   o_we_n,
	output logic                   o_re_n,
	output logic      [7:0]        o_io_out,
	output logic                   o_io_oe,
	input  wire logic [7:0]        i_io_in
);
	typedef enum logic [2:0] {E_IDLE, E_GAP, E_LO, E_HI, E_WAIT} nbb_est_e;
	nbb_est_e           st_r, st_nxt;
	nbb_pkg::nbb_kind_e kind_r, kind_nxt;
	logic [7:0]         cnt_r, cnt_nxt, byte_r, byte_nxt, io_r, io_nxt;
	logic               rdf_r, rdf_nxt, done_nxt, cle_nxt, ale_nxt, we_nxt, re_nxt, oe_nxt, go_lo;

	always_comb begin
		st_nxt = st_r; kind_nxt = kind_r; cnt_nxt = cnt_r; byte_nxt = byte_r; io_nxt = io_r;
		rdf_nxt = rdf_r; done_nxt = 1'b0; cle_nxt = o_cle; ale_nxt = o_ale;
		we_nxt = o_we_n; re_nxt = o_re_n; oe_nxt = o_io_oe; go_lo = 1'b0;
		case (st_r)
			E_IDLE: begin
				if (i_start) begin
					kind_nxt = i_kind;
					io_nxt   = i_byte;
					if (i_kind == nbb_pkg::NBB_K_WAIT) begin
						cnt_nxt = i_wait;
						st_nxt  = E_WAIT;
					end else if (i_kind != nbb_pkg::NBB_K_DOUT && rdf_r) begin
						// A write strobe after a read must keep clear of the read.
						cnt_nxt = nbb_pkg::RHW_CYC;
						st_nxt  = E_GAP;
					end else begin
						go_lo = 1'b1;
					end
				end
			end
			E_GAP: begin
				cnt_nxt = cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					go_lo = 1'b1;
				end
			end
			E_LO: begin
				cnt_nxt = cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					st_nxt = E_HI;
					if (kind_r == nbb_pkg::NBB_K_DOUT) begin
						byte_nxt = i_io_in;
						re_nxt   = 1'b1;
						rdf_nxt  = 1'b1;
						cnt_nxt  = nbb_pkg::REH_CYC;
					end else begin
						we_nxt  = 1'b1;
						cnt_nxt = nbb_pkg::WH_CYC;
					end
				end
			end
			E_HI: begin
				cnt_nxt = cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					st_nxt   = E_IDLE;
					done_nxt = 1'b1;
					cle_nxt  = 1'b0;
					ale_nxt  = 1'b0;
					oe_nxt   = 1'b0;
				end
			end
			E_WAIT: begin
				cnt_nxt = cnt_r - 8'h01;
				if (cnt_r <= 8'h01) begin
					st_nxt   = E_IDLE;
					done_nxt = 1'b1;
				end
			end
			default: st_nxt = E_IDLE;
		endcase
		if (go_lo) begin
			st_nxt = E_LO;
			if (kind_nxt == nbb_pkg::NBB_K_DOUT) begin
				re_nxt  = 1'b0;
				oe_nxt  = 1'b0;
				cnt_nxt = nbb_pkg::RLO_CYC;
			end else begin
				cle_nxt = (kind_nxt == nbb_pkg::NBB_K_CMD);
				ale_nxt = (kind_nxt == nbb_pkg::NBB_K_ADDR);
				oe_nxt  = 1'b1;
				we_nxt  = 1'b0;
				rdf_nxt = 1'b0;
				cnt_nxt = nbb_pkg::WP_CYC;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r <= E_IDLE; kind_r <= nbb_pkg::NBB_K_WAIT; cnt_r <= 8'h00; byte_r <= 8'h00;
			io_r <= 8'h00; rdf_r <= 1'b0; o_done <= 1'b0; o_cle <= 1'b0; o_ale <= 1'b0;
			o_we_n <= 1'b1; o_re_n <= 1'b1; o_io_oe <= 1'b0;
		end else begin
			st_r <= st_nxt; kind_r <= kind_nxt; cnt_r <= cnt_nxt; byte_r <= byte_nxt;
			io_r <= io_nxt; rdf_r <= rdf_nxt; o_done <= done_nxt; o_cle <= cle_nxt; o_ale <= ale_nxt;
			o_we_n <= we_nxt; o_re_n <= re_nxt; o_io_oe <= oe_nxt;
		end
	end

	assign o_byte   = byte_r;
	assign o_io_out = io_r;
endmodule
`default_nettype wire

// ===== logic/nbb_host.sv
// Purpose: Host-side sequencer for a byte-wide NAND array with bad-block management.
// Assumes: R/B high means ready; user supplies ECC on the read stream.
// Notes:   Spares are taken downward from the last block; keep those free.
// What this block does
// - Scan every block's byte 2048 for FFh.
// - Never erase or program a factory-bad block.
// - Finish the scan before any erase or program.
// - Keep a bad table and remap failing blocks.
// - Check status after erase or program; replace on failure.
// - Failed page goes to an erased replacement block; this block only picks the spare and reports it to the caller.
// - Every read gets 4-bit per 512-byte correction; this block only marks each unit end for the user's ECC.
// - Read errors never retire a block.
// - Program pages in ascending order within a block.
// - First programmed page may be any page.
// - Column cycles carry A0-A7 then A8-A11.
// - Row cycles carry A12-A19 then A20-A26.
// - Status read may follow the read confirm.
`timescale 1ns/1ps
`default_nettype none
module nbb_host (
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	// Requests and results
	input  wire logic              i_req_valid,
	input  wire nbb_pkg::nbb_req_s i_req,
	output logic                   o_busy,
	output logic                   o_done,
	output nbb_pkg::nbb_res_s      o_res,
	output logic                   o_scan_done,
	// Program data
	input  wire logic              i_wr_valid,
	input  wire logic [7:0]        i_wr_data,
	output logic                   o_wr_taken,
	// Read data
	output logic                   o_rd_valid,
	output logic      [7:0]        o_rd_data,
	output logic                   o_rd_unit_end,
	// Flash pins
	output logic                   o_ce_n,
	output logic                   o_cle,
	output logic                   o_ale,
	output logic                   o_we_n,
	output logic                   o_re_n,
	output logic                   o_wp_n,
	output logic      [7:0]        o_io_out,
	output logic                   o_io_oe,
	input  wire logic [7:0]        i_io_in,
	input  wire logic              i_rb
);
	typedef enum logic [3:0] {S_IDLE, S_CHECK, S_CMD1, S_ADDR, S_ADL, S_DATA, S_CMD2, S_TWB,
		S_RBWAIT, S_STCMD, S_STWHR, S_STRD, S_RDMODE, S_REPL, S_FINISH} nbb_st_e;
	nbb_st_e            st_r, st_nxt;
	nbb_pkg::nbb_op_e   op_r, op_nxt;
	nbb_pkg::nbb_res_s  res_r, res_nxt;
	nbb_pkg::nbb_kind_e eng_kind;
	logic [8:0]         lblk_r, lblk_nxt, pblk_r, pblk_nxt, spare_r, spare_nxt, phys, map_wd, mw_a;
	logic [5:0]         page_r, page_nxt;
	logic [1:0]         idx_r, idx_nxt;
	logic [11:0]        bcnt_r, bcnt_nxt, col;
	logic [7:0]         eng_byte, eng_wait, eng_rd, addr_byte, rd_data_nxt;
	logic               pend_r, pend_nxt, scan_done_nxt, done_nxt, busy_nxt, ce_n_nxt, wp_n_nxt;
	logic               wr_taken_nxt, rd_valid_nxt, unit_end_nxt, eng_start, eng_done, use_eng, issue_ok;
	logic               fin, is_pe, bad_we, bad_wd, used_we, used_wd, last_we, map_we, mapped_wd;
	// Per-block tables; the scan fills all but last_r for every block.
	logic               bad_r    [512];
	logic               used_r   [512];
	logic [5:0]         last_r   [512];
	logic               mapped_r [512];
	logic [8:0]         map_r    [512];

	assign col = (op_r == nbb_pkg::NBB_OP_SCAN) ? nbb_pkg::MARK_COL : 12'h000;
	assign is_pe = (op_r == nbb_pkg::NBB_OP_PROG) || (op_r == nbb_pkg::NBB_OP_ERASE);
	assign fin = pend_r && eng_done;
	assign phys = (o_scan_done && mapped_r[lblk_r]) ? map_r[lblk_r] : lblk_r;

	nbb_addr u_addr (
		.i_col  (col),
		.i_row  ({pblk_r, page_r}),
		.i_idx  (idx_r),
		.o_byte (addr_byte)
	);

	nbb_cycle u_cycle (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_start  (eng_start),
		.i_kind   (eng_kind),
		.i_byte   (eng_byte),
		.i_wait   (eng_wait),
		.o_done   (eng_done),
		.o_byte   (eng_rd),
		.o_cle    (o_cle),
		.o_ale    (o_ale),
		.o_we_n   (o_we_n),
		.o_re_n   (o_re_n),
		.o_io_out (o_io_out),
		.o_io_oe  (o_io_oe),
		.i_io_in  (i_io_in)
	);

	always_comb begin
		st_nxt = st_r; op_nxt = op_r; res_nxt = res_r; lblk_nxt = lblk_r; pblk_nxt = pblk_r;
		spare_nxt = spare_r; page_nxt = page_r; idx_nxt = idx_r; bcnt_nxt = bcnt_r;
		scan_done_nxt = o_scan_done; done_nxt = 1'b0; busy_nxt = o_busy; ce_n_nxt = o_ce_n;
		wp_n_nxt = 1'b1; rd_valid_nxt = 1'b0; rd_data_nxt = o_rd_data; unit_end_nxt = 1'b0;
		use_eng = 1'b0; issue_ok = 1'b1; eng_kind = nbb_pkg::NBB_K_WAIT; eng_byte = 8'h00;
		eng_wait = 8'h01; bad_we = 1'b0; bad_wd = 1'b0; used_we = 1'b0; used_wd = 1'b0;
		last_we = 1'b0; map_we = 1'b0; map_wd = spare_r; mapped_wd = 1'b0; mw_a = lblk_r;
		case (st_r)
			S_IDLE: begin
				if (i_req_valid) begin
					op_nxt   = i_req.op;
					lblk_nxt = i_req.block;
					page_nxt = i_req.page;
					res_nxt  = '0;
					busy_nxt = 1'b1;
					ce_n_nxt = 1'b0;
					if (i_req.op == nbb_pkg::NBB_OP_SCAN) begin
						pblk_nxt = 9'h000;
						page_nxt = 6'h00;
						idx_nxt  = 2'h0;
						st_nxt   = S_CMD1;
					end else begin
						st_nxt = S_CHECK;
					end
				end
			end
			S_CHECK: begin
				pblk_nxt  = phys;
				res_nxt.block = phys;
				idx_nxt   = (op_r == nbb_pkg::NBB_OP_ERASE) ? nbb_pkg::ROW_FIRST : 2'h0;
				st_nxt    = S_CMD1;
				if (is_pe && !o_scan_done) begin
					res_nxt.refused = 1'b1;
					st_nxt = S_FINISH;
				end else if (is_pe && bad_r[phys]) begin
					res_nxt.refused = 1'b1;
					st_nxt = S_FINISH;
				end else if (op_r == nbb_pkg::NBB_OP_PROG && used_r[phys] && page_r <= last_r[phys]) begin
					// An erased block accepts any first page; later ones must climb.
					res_nxt.refused = 1'b1;
					st_nxt = S_FINISH;
				end
			end
			S_CMD1: begin
				use_eng  = 1'b1;
				eng_kind = nbb_pkg::NBB_K_CMD;
				case (op_r)
					nbb_pkg::NBB_OP_PROG:  eng_byte = nbb_pkg::CMD_PG1;
					nbb_pkg::NBB_OP_ERASE: eng_byte = nbb_pkg::CMD_ER1;
					default:               eng_byte = nbb_pkg::CMD_RD1;
				endcase
				if (fin) begin
					st_nxt = S_ADDR;
				end
			end
			S_ADDR: begin
				use_eng  = 1'b1;
				eng_kind = nbb_pkg::NBB_K_ADDR;
				eng_byte = addr_byte;
				if (fin) begin
					idx_nxt = idx_r + 2'h1;
					if (idx_r == nbb_pkg::ADDR_LAST) begin
						st_nxt = (op_r == nbb_pkg::NBB_OP_PROG) ? S_ADL : S_CMD2;
					end
				end
			end
			S_ADL: begin
				use_eng  = 1'b1;
				eng_wait = nbb_pkg::ADL_CYC;
				bcnt_nxt = 12'h000;
				if (fin) begin
					st_nxt = S_DATA;
				end
			end
			S_DATA: begin
				use_eng = 1'b1;
				if (op_r == nbb_pkg::NBB_OP_PROG) begin
					eng_kind = nbb_pkg::NBB_K_DIN;
					eng_byte = i_wr_data;
					issue_ok = i_wr_valid;
				end else begin
					eng_kind = nbb_pkg::NBB_K_DOUT;
				end
				if (fin) begin
					bcnt_nxt = bcnt_r + 12'h001;
					if (op_r == nbb_pkg::NBB_OP_SCAN) begin
						bad_we  = 1'b1;
						bad_wd  = (eng_rd != nbb_pkg::GOOD_MARK);
						used_we = 1'b1;
						map_we  = 1'b1;
						mw_a    = pblk_r;
						if (pblk_r == nbb_pkg::LAST_BLK) begin
							scan_done_nxt = 1'b1;
							res_nxt.ok    = 1'b1;
							st_nxt        = S_FINISH;
						end else begin
							pblk_nxt = pblk_r + 9'h001;
							idx_nxt  = 2'h0;
							st_nxt   = S_CMD1;
						end
					end else if (op_r == nbb_pkg::NBB_OP_READ) begin
						// Correction happens downstream per unit; a read never retires a block.
						rd_valid_nxt = 1'b1;
						rd_data_nxt  = eng_rd;
						unit_end_nxt = (bcnt_r[8:0] == nbb_pkg::UNIT_LAST) || (bcnt_r == nbb_pkg::PAGE_LAST);
						if (bcnt_r == nbb_pkg::PAGE_LAST) begin
							res_nxt.ok = 1'b1;
							st_nxt     = S_FINISH;
						end
					end else if (bcnt_r == nbb_pkg::PAGE_LAST) begin
						st_nxt = S_CMD2;
					end
				end
			end
			S_CMD2: begin
				use_eng  = 1'b1;
				eng_kind = nbb_pkg::NBB_K_CMD;
				case (op_r)
					nbb_pkg::NBB_OP_PROG:  eng_byte = nbb_pkg::CMD_PG2;
					nbb_pkg::NBB_OP_ERASE: eng_byte = nbb_pkg::CMD_ER2;
					default:               eng_byte = nbb_pkg::CMD_RD2;
				endcase
				if (fin) begin
					st_nxt = S_TWB;
				end
			end
			S_TWB: begin
				use_eng  = 1'b1;
				eng_wait = nbb_pkg::WB_CYC;
				if (fin) begin
					st_nxt = is_pe ? S_RBWAIT : S_STCMD;
				end
			end
			S_RBWAIT: begin
				if (i_rb) begin
					st_nxt = S_STCMD;
				end
			end
			S_STCMD: begin
				use_eng  = 1'b1;
				eng_kind = nbb_pkg::NBB_K_CMD;
				eng_byte = nbb_pkg::CMD_STAT;
				if (fin) begin
					st_nxt = S_STWHR;
				end
			end
			S_STWHR: begin
				use_eng  = 1'b1;
				eng_wait = nbb_pkg::WHR_CYC;
				if (fin) begin
					st_nxt = S_STRD;
				end
			end
			S_STRD: begin
				use_eng  = 1'b1;
				eng_kind = nbb_pkg::NBB_K_DOUT;
				if (fin && eng_rd[nbb_pkg::ST_RDY]) begin
					if (!is_pe) begin
						st_nxt = S_RDMODE;
					end else if (eng_rd[nbb_pkg::ST_FAIL]) begin
						bad_we = 1'b1;
						bad_wd = 1'b1;
						res_nxt.failed = 1'b1;
						st_nxt = S_REPL;
					end else begin
						used_we = 1'b1;
						used_wd = (op_r == nbb_pkg::NBB_OP_PROG);
						last_we = 1'b1;
						res_nxt.ok = 1'b1;
						st_nxt = S_FINISH;
					end
				end
			end
			S_RDMODE: begin
				use_eng  = 1'b1;
				eng_kind = nbb_pkg::NBB_K_CMD;
				eng_byte = nbb_pkg::CMD_RD1;
				bcnt_nxt = 12'h000;
				if (fin) begin
					st_nxt = S_DATA;
				end
			end
			S_REPL: begin
				if (spare_r == nbb_pkg::SAFE_BLK) begin
					res_nxt.no_spare = 1'b1;
					st_nxt = S_FINISH;
				end else if (bad_r[spare_r]) begin
					spare_nxt = spare_r - 9'h001;
				end else begin
					// The caller erases the spare, rewrites the failed page from its buffer and copies the rest.
					map_we    = 1'b1;
					mapped_wd = 1'b1;
					res_nxt.remapped = 1'b1;
					res_nxt.block    = spare_r;
					spare_nxt = spare_r - 9'h001;
					st_nxt    = S_FINISH;
				end
			end
			S_FINISH: begin
				done_nxt = 1'b1;
				busy_nxt = 1'b0;
				ce_n_nxt = 1'b1;
				st_nxt   = S_IDLE;
			end
			default: st_nxt = S_IDLE;
		endcase
		eng_start = use_eng && !pend_r && issue_ok;
		pend_nxt  = eng_start ? 1'b1 : (fin ? 1'b0 : pend_r);
		wr_taken_nxt = eng_start && (eng_kind == nbb_pkg::NBB_K_DIN);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r <= S_IDLE; op_r <= nbb_pkg::NBB_OP_SCAN; res_r <= '0; lblk_r <= 9'h000;
			pblk_r <= 9'h000; spare_r <= nbb_pkg::LAST_BLK; page_r <= 6'h00; idx_r <= 2'h0;
			bcnt_r <= 12'h000; pend_r <= 1'b0; o_scan_done <= 1'b0; o_done <= 1'b0; o_busy <= 1'b0;
			o_ce_n <= 1'b1; o_wp_n <= 1'b0; o_wr_taken <= 1'b0; o_rd_valid <= 1'b0;
			o_rd_data <= 8'h00; o_rd_unit_end <= 1'b0;
		end else begin
			st_r <= st_nxt; op_r <= op_nxt; res_r <= res_nxt; lblk_r <= lblk_nxt;
			pblk_r <= pblk_nxt; spare_r <= spare_nxt; page_r <= page_nxt; idx_r <= idx_nxt;
			bcnt_r <= bcnt_nxt; pend_r <= pend_nxt; o_scan_done <= scan_done_nxt; o_done <= done_nxt;
			o_busy <= busy_nxt; o_ce_n <= ce_n_nxt; o_wp_n <= wp_n_nxt; o_wr_taken <= wr_taken_nxt;
			o_rd_valid <= rd_valid_nxt; o_rd_data <= rd_data_nxt; o_rd_unit_end <= unit_end_nxt;
		end
	end

	// Tables carry no reset; the scan writes every entry but last_r before they steer anything, and last_r is set with used_r.
	always_ff @(posedge i_clk) begin
		if (bad_we) bad_r[pblk_r] <= bad_wd;
		if (used_we) used_r[pblk_r] <= used_wd;
		if (last_we) last_r[pblk_r] <= page_r;
		if (map_we) mapped_r[mw_a] <= mapped_wd;
		if (map_we) map_r[mw_a] <= map_wd;
	end

	assign o_res = res_r;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_scan_mark_col: assert property ((st_r == S_ADDR && op_r == nbb_pkg::NBB_OP_SCAN && eng_start && idx_r == 2'h1)
		|-> eng_byte == 8'h08) else $error("scan column not 2048");
	a_pe_after_scan: assert property ((eng_start && eng_kind == nbb_pkg::NBB_K_CMD &&
		(eng_byte == 8'h80 || eng_byte == 8'h60)) |-> o_scan_done) else $error("erase or program before scan");
	a_pe_not_bad: assert property ((eng_start && st_r == S_CMD1 && is_pe) |-> !bad_r[pblk_r])
		else $error("erase or program on bad block");
	a_fail_retires: assert property ((st_r == S_STRD && fin && is_pe && eng_rd[6] && eng_rd[0])
		|=> st_r == S_REPL && bad_r[pblk_r]) else $error("failed block not retired");
	a_ready_before_st: assert property ((st_r == S_STCMD && eng_start && is_pe) |-> $past(i_rb))
		else $error("status issued before ready");
	a_page_ascend: assert property ((st_r == S_CMD1 && eng_start && op_r == nbb_pkg::NBB_OP_PROG
		&& used_r[pblk_r]) |-> page_r > last_r[pblk_r]) else $error("page order violated");
	a_read_polls: assert property ((st_r == S_TWB && fin && !is_pe) |=> st_r == S_STCMD ##[1:20]
		(o_cle && !o_we_n && o_io_out == 8'h70)) else $error("no status after read confirm");
	a_spare_nonzero: assert property (map_we && mapped_wd |-> map_wd != 9'h000)
		else $error("block zero used as spare");
	a_unit_mark: assert property (o_rd_unit_end |-> o_rd_valid && op_r == nbb_pkg::NBB_OP_READ)
		else $error("unit end without data");
	a_read_keeps: assert property ((op_r == nbb_pkg::NBB_OP_READ && st_r == S_DATA) |-> !bad_we)
		else $error("read retired a block");
	a_row_byte: assert property ((eng_start && st_r == S_ADDR && idx_r == 2'h2)
		|-> eng_byte == {pblk_r[1:0], page_r}) else $error("row byte wrong");
	a_remap_sets: assert property ((st_r == S_REPL && map_we) |-> ##2 (o_done && o_res.remapped))
		else $error("remap not reported");

	c_scan_end: cover property (o_done && o_scan_done);
	c_prog_ok: cover property (o_done && o_res.ok && op_r == nbb_pkg::NBB_OP_PROG);
	c_remap: cover property (o_done && o_res.remapped);
	c_unit: cover property (o_rd_unit_end);
endmodule
`default_nettype wire

// ===== logic/nbb_pkg.sv
// Purpose: Shared constants, types and carriers of the NAND host sequencer.
// Assumes: 100 MHz clock; byte-wide multiplexed flash port.
// Notes:   Cycle counts derive from the printed nanosecond figures.
package nbb_pkg;
	localparam int unsigned CLK_MHZ   = 100;
	// Least times in ns, rounded up to whole clock cycles below, with one cycle more for RLO_CYC.
	localparam int unsigned T_WP_NS   = 12;
	localparam int unsigned T_WH_NS   = 10;
	localparam int unsigned T_REA_NS  = 20;
	localparam int unsigned T_REH_NS  = 10;
	localparam int unsigned T_WB_NS   = 100;
	localparam int unsigned T_WHR_NS  = 60;
	localparam int unsigned T_ADL_NS  = 100;
	localparam int unsigned T_RHW_NS  = 100;
	localparam logic [7:0]  WP_CYC    = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  WH_CYC    = 8'((T_WH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  RLO_CYC   = 8'((T_REA_NS * CLK_MHZ + 999) / 1000 + 1);
	localparam logic [7:0]  REH_CYC   = 8'((T_REH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  WB_CYC    = 8'((T_WB_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  WHR_CYC   = 8'((T_WHR_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  ADL_CYC   = 8'((T_ADL_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  RHW_CYC   = 8'((T_RHW_NS * CLK_MHZ + 999) / 1000);
	// Command bytes.
	localparam logic [7:0]  CMD_RD1   = 8'h00;
	localparam logic [7:0]  CMD_RD2   = 8'h30;
	localparam logic [7:0]  CMD_PG1   = 8'h80;
	localparam logic [7:0]  CMD_PG2   = 8'h10;
	localparam logic [7:0]  CMD_ER1   = 8'h60;
	localparam logic [7:0]  CMD_ER2   = 8'hd0;
	localparam logic [7:0]  CMD_STAT  = 8'h70;
	// Array geometry, marker and status bits.
	localparam logic [11:0] MARK_COL  = 12'h800;
	localparam logic [7:0]  GOOD_MARK = 8'hff;
	localparam logic [11:0] PAGE_LAST = 12'h83f;
	localparam logic [8:0]  UNIT_LAST = 9'h1ff;
	localparam logic [8:0]  LAST_BLK  = 9'h1ff;
	localparam logic [8:0]  SAFE_BLK  = 9'h000;
	localparam int unsigned ST_RDY    = 6;
	localparam int unsigned ST_FAIL   = 0;
	localparam logic [1:0]  ADDR_LAST = 2'h3;
	localparam logic [1:0]  ROW_FIRST = 2'h2;

	typedef enum logic [2:0] {NBB_OP_SCAN, NBB_OP_READ, NBB_OP_PROG, NBB_OP_ERASE} nbb_op_e;
	typedef enum logic [2:0] {NBB_K_CMD, NBB_K_ADDR, NBB_K_DIN, NBB_K_DOUT, NBB_K_WAIT} nbb_kind_e;

	typedef struct packed {
		nbb_op_e    op;
		logic [8:0] block;
		logic [5:0] page;
	} nbb_req_s;

	typedef struct packed {
		logic       ok;
		logic       refused;
		logic       failed;
		logic       remapped;
		logic       no_spare;
		logic [8:0] block;
	} nbb_res_s;
endpackage
